// ==== include/pls_cfg.svh ====
// How it works
// RQ1: four-bit indicator source, reset 0x8; codes 0-4 link, activity, tx, rx, collision.
// RQ2: codes 5-8 show 100 Mb/s, 10 Mb/s, full duplex, link blinking on activity.
// RQ3: codes 9-C show stretched activity, 100 full duplex, low-power idle, mii error.
// RQ4: code D lights on link loss until basic status at 0x0001 is read.
// RQ5: code E lights on any prbs error until the error counter clears.
// RQ6: routing bit, reset one, selects link status (0) or indicator source (1).
// RQ7: bit 4 at 0x0027 enables 10 Mb/s tests; bit 4 at 0x0428 enables 100.
// RQ8: 10 Mb/s codes 0-4: link pulse, positive, negative, repeated one, repeated zero.
// RQ9: codes 5-9: preamble, one then idle, zero then idle, 1001 repeat, random.
// RQ10: codes A-D give the four line idle pulse variants in code order.
// RQ11: five-bit count from 0x0428 bit 5 over field sends one then that many zeros.
// RQ12: a count of zero clears the pattern shift register instead.
// RQ13: software clears the 100 enable, writes pattern, then sets enable again.
// RQ14: software forces link speed in basic mode control before any test.
// RQ15: reserved bits read zero and ignore writes.
`ifndef PLS_CFG_SVH
`define PLS_CFG_SVH
// ---------------------------------
// register map
// ---------------------------------
`define PLS_ADR_BSR 16'h0001
`define PLS_ADR_IND 16'h0025
`define PLS_ADR_CMP 16'h0027
`define PLS_ADR_TXM 16'h0428
// ---------------------------------
// fields and resets
// ---------------------------------
`define PLS_IND_SRC_HI 6
`define PLS_IND_SRC_LO 3
`define PLS_IND_ROUTE 0
`define PLS_CMP_EN 4
`define PLS_TXM_EN 4
`define PLS_TXM_MSB 5
`define PLS_SRC_RST 4'h8
`define PLS_ROUTE_RST 1'b1
`define PLS_CMP_RST 5'h00
`define PLS_TXM_RST 2'h0
// ---------------------------------
// indicator source codes
// ---------------------------------
`define PLS_SRC_LINK 4'h0
`define PLS_SRC_ACT 4'h1
`define PLS_SRC_TXA 4'h2
`define PLS_SRC_RXA 4'h3
`define PLS_SRC_COL 4'h4
`define PLS_SRC_S100 4'h5
`define PLS_SRC_S10 4'h6
`define PLS_SRC_FDX 4'h7
`define PLS_SRC_BLNK 4'h8
`define PLS_SRC_STR 4'h9
`define PLS_SRC_L100 4'ha
`define PLS_SRC_LPI 4'hb
`define PLS_SRC_ERR 4'hc
`define PLS_SRC_LOST 4'hd
`define PLS_SRC_PRBS 4'he
// ---------------------------------
// timing
// ---------------------------------
`define PLS_CLK_NS 10
`define PLS_BLINK_MS 50
`define PLS_STRETCH_MS 50
`endif

// ==== include/pls_pkg.sv ====
package pls_pkg;
  typedef struct packed {
    logic link_up;
    logic act_any;
    logic act_tx;
    logic act_rx;
    logic col;
    logic spd100;
    logic spd10;
    logic fdx;
    logic lpi;
    logic mii_err;
    logic prbs_err;
    logic prbs_clr;
  } pls_stat_s;
  typedef struct packed {
    logic en;
    logic [3:0] code;
  } pls_tp10_s;
  typedef struct packed {
    logic en;
    logic tx_bit;
    logic sr_clr;
  } pls_txm_s;
  typedef enum logic [1:0] {
    PLS_IDLE = 2'b00,
    PLS_ONE = 2'b01,
    PLS_ZERO = 2'b11
  } pls_pat_e;
endpackage

// ==== src/pls_pattern.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pls_cfg.svh"
module pls_pattern (
  input wire logic i_clk, // core clock
  input wire logic i_nrst, // async reset, low
  input wire logic i_en10, // 10 Mb/s test enable
  input wire logic [3:0] i_code, // test field
  input wire logic i_en100, // 100 Mb/s test enable
  input wire logic i_msb, // count bit 4
  output pls_pkg::pls_tp10_s o_tp10, // 10 Mb/s pattern select
  output pls_pkg::pls_txm_s o_txm // 100 Mb/s test bit stream
);
  pls_pkg::pls_pat_e st_q;
  pls_pkg::pls_tp10_s tp10_q;
  logic [4:0] n_q;
  logic [4:0] zc_q;
  logic en_q;
  logic clr_q;
  logic rise;

  assign rise = i_en100 && !en_q;

  // ---------------------------------
  // 10 Mb/s pattern select to encoder
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      tp10_q <= '0;
    else
    begin
      tp10_q.en <= i_en10; // RQ7
      tp10_q.code <= i_code; // RQ8 RQ9 RQ10
    end
  end

  // ---------------------------------
  // one followed by n zeros
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_q <= pls_pkg::PLS_IDLE;
      n_q <= 5'h00;
      zc_q <= 5'h00;
      en_q <= 1'b0;
      clr_q <= 1'b0;
    end
    else
    begin
      en_q <= i_en100;
      // count taken only when enable rises
      if (!i_en100)
      begin
        st_q <= pls_pkg::PLS_IDLE; // RQ7
        clr_q <= 1'b0;
      end
      else if (rise)
      begin
        n_q <= {i_msb, i_code}; // RQ11 RQ13
        clr_q <= ({i_msb, i_code} == 5'h00); // RQ12
        st_q <= ({i_msb, i_code} == 5'h00) ? pls_pkg::PLS_IDLE : pls_pkg::PLS_ONE;
      end
      else
      begin
        unique case (st_q)
          pls_pkg::PLS_IDLE: st_q <= pls_pkg::PLS_IDLE;
          pls_pkg::PLS_ONE:
          begin
            st_q <= pls_pkg::PLS_ZERO;
            zc_q <= 5'h01;
          end
          pls_pkg::PLS_ZERO:
          begin
            if (zc_q == n_q)
              st_q <= pls_pkg::PLS_ONE; // RQ11
            else
              zc_q <= zc_q + 5'h01;
          end
          default: st_q <= pls_pkg::PLS_IDLE;
        endcase
      end
    end
  end

  assign o_tp10 = tp10_q;
  assign o_txm.en = en_q;
  assign o_txm.tx_bit = (st_q == pls_pkg::PLS_ONE);
  assign o_txm.sr_clr = clr_q;

  one_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ11
    (st_q == pls_pkg::PLS_ONE && n_q == 5'h02 && i_en100 && !rise)
    |=> !o_txm.tx_bit ##1 !o_txm.tx_bit
    ##1 (o_txm.tx_bit || !$past(i_en100) || !$past(i_en100, 2)))
    else $error("two zeros after one not produced");
  zero_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ12
    (rise && {i_msb, i_code} == 5'h00)
    |=> (o_txm.sr_clr && !o_txm.tx_bit) ##1 (!o_txm.tx_bit [*2]))
    else $error("zero count did not clear shift register");
  tp10_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ7
    ##1 o_tp10.en == $past(i_en10))
    else $error("10M test enable does not follow");
endmodule // pls_pattern
`default_nettype wire

// ==== src/pls_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pls_cfg.svh"
module pls_top #(
  parameter int BLINK_CYC = `PLS_BLINK_MS * 1000000 / `PLS_CLK_NS,
  parameter int STRETCH_CYC = `PLS_STRETCH_MS * 1000000 / `PLS_CLK_NS
) (
  input wire logic i_clk, // core clock, 100 MHz
  input wire logic i_nrst, // async reset, low
  input wire logic [15:0] i_addr, // register address
  input wire logic [15:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [15:0] o_rdata, // read data, cycle after strobe
  input wire pls_pkg::pls_stat_s i_stat, // phy status levels
  output logic o_led, // primary_indicator_pin
  output pls_pkg::pls_tp10_s o_tp10, // 10 Mb/s pattern select
  output pls_pkg::pls_txm_s o_txm // 100 Mb/s test stream
);
  logic [3:0] src_q;
  logic route_q;
  logic [4:0] cmp_q;
  logic [1:0] txm_q;
  logic [15:0] rdata_q;
  logic link_prev_q;
  logic lost_q;
  logic prbs_q;
  logic [31:0] blk_cnt_q;
  logic blink_q;
  logic [31:0] str_cnt_q;
  logic stretch;
  logic led_d;
  logic led_q;
  logic bsr_rd;
  logic link_fell;

  assign bsr_rd = i_rd && (i_addr == `PLS_ADR_BSR);
  assign link_fell = link_prev_q && !i_stat.link_up;
  assign stretch = (str_cnt_q != 32'h0000_0000);

  // ---------------------------------
  // register writes
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      src_q <= `PLS_SRC_RST; // RQ1
      route_q <= `PLS_ROUTE_RST; // RQ6
      cmp_q <= `PLS_CMP_RST;
      txm_q <= `PLS_TXM_RST;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        `PLS_ADR_IND:
        begin
          src_q <= i_wdata[`PLS_IND_SRC_HI:`PLS_IND_SRC_LO]; // RQ1
          route_q <= i_wdata[`PLS_IND_ROUTE]; // RQ6
        end
        `PLS_ADR_CMP: cmp_q <= i_wdata[`PLS_CMP_EN:0]; // RQ7 RQ15
        `PLS_ADR_TXM:
          txm_q <= i_wdata[`PLS_TXM_MSB:`PLS_TXM_EN]; // RQ11 RQ15
        default: ;
      endcase
    end
  end

  // ---------------------------------
  // register reads
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      rdata_q <= 16'h0000;
    else if (i_rd)
    begin
      rdata_q <= 16'h0000; // RQ15
      unique case (i_addr)
        `PLS_ADR_IND:
        begin
          rdata_q[`PLS_IND_SRC_HI:`PLS_IND_SRC_LO] <= src_q;
          rdata_q[`PLS_IND_ROUTE] <= route_q;
        end
        `PLS_ADR_CMP: rdata_q[`PLS_CMP_EN:0] <= cmp_q;
        `PLS_ADR_TXM: rdata_q[`PLS_TXM_MSB:`PLS_TXM_EN] <= txm_q;
        default: ;
      endcase
    end
    else
      rdata_q <= 16'h0000;
  end

  assign o_rdata = rdata_q;

  // ---------------------------------
  // sticky link-lost and prbs flags
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      link_prev_q <= 1'b0;
      lost_q <= 1'b0;
    end
    else
    begin
      link_prev_q <= i_stat.link_up;
      // set wins over the status read
      if (link_fell)
        lost_q <= 1'b1; // RQ4
      else if (bsr_rd)
        lost_q <= 1'b0; // RQ4
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      prbs_q <= 1'b0;
    else if (i_stat.prbs_err)
      prbs_q <= 1'b1; // RQ5
    else if (i_stat.prbs_clr)
      prbs_q <= 1'b0; // RQ5
  end

  // ---------------------------------
  // blink and activity stretch timers
  // ---------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      blk_cnt_q <= 32'h0000_0000;
      blink_q <= 1'b0;
    end
    else if (blk_cnt_q == 32'(BLINK_CYC - 1))
    begin
      blk_cnt_q <= 32'h0000_0000;
      blink_q <= !blink_q;
    end
    else
      blk_cnt_q <= blk_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      str_cnt_q <= 32'h0000_0000;
    else if (i_stat.act_any)
      str_cnt_q <= 32'(STRETCH_CYC);
    else if (stretch)
      str_cnt_q <= str_cnt_q - 32'h0000_0001;
  end

  // ---------------------------------
  // indicator source mux
  // ---------------------------------
  always_comb
  begin
    led_d = 1'b0;
    unique case (src_q)
      `PLS_SRC_LINK: led_d = i_stat.link_up; // RQ1
      `PLS_SRC_ACT: led_d = i_stat.act_any; // RQ1
      `PLS_SRC_TXA: led_d = i_stat.act_tx; // RQ1
      `PLS_SRC_RXA: led_d = i_stat.act_rx; // RQ1
      `PLS_SRC_COL: led_d = i_stat.col; // RQ1
      `PLS_SRC_S100: led_d = i_stat.spd100; // RQ2
      `PLS_SRC_S10: led_d = i_stat.spd10; // RQ2
      `PLS_SRC_FDX: led_d = i_stat.fdx; // RQ2
      `PLS_SRC_BLNK: led_d = i_stat.link_up && !(stretch && blink_q); // RQ2
      `PLS_SRC_STR: led_d = stretch; // RQ3
      `PLS_SRC_L100: led_d = i_stat.link_up && i_stat.spd100 && i_stat.fdx; // RQ3
      `PLS_SRC_LPI: led_d = i_stat.lpi; // RQ3
      `PLS_SRC_ERR: led_d = i_stat.mii_err; // RQ3
      `PLS_SRC_LOST: led_d = lost_q; // RQ4
      `PLS_SRC_PRBS: led_d = prbs_q; // RQ5
      default: led_d = 1'b0; // RQ3
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      led_q <= 1'b0;
    else
      led_q <= route_q ? led_d : i_stat.link_up; // RQ6
  end

  assign o_led = led_q;

  // ---------------------------------
  // test pattern generator
  // ---------------------------------
  pls_pattern u_pat (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_en10(cmp_q[`PLS_CMP_EN]),
    .i_code(cmp_q[3:0]),
    .i_en100(txm_q[0]),
    .i_msb(txm_q[1]),
    .o_tp10(o_tp10),
    .o_txm(o_txm)
  );

  // ---------------------------------
  // checks
  // ---------------------------------
  src_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ1
    (i_wr && i_addr == `PLS_ADR_IND)
    |=> src_q == $past(i_wdata[6:3]) && route_q == $past(i_wdata[0]))
    else $error("indicator config write not stored");
  route_link_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ6
    !route_q |=> o_led == $past(i_stat.link_up))
    else $error("routing off but pin not link status");
  speed_src_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ2
    (route_q && src_q == `PLS_SRC_S100) |=> o_led == $past(i_stat.spd100))
    else $error("100M source not shown");
  lpi_src_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ3
    (route_q && src_q == `PLS_SRC_LPI) |=> o_led == $past(i_stat.lpi))
    else $error("low power idle source not shown");
  lost_set_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
    link_fell |=> lost_q ##1 (lost_q || $past(bsr_rd)))
    else $error("link loss not latched");
  lost_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ4
    (bsr_rd && !link_fell) |=> !lost_q)
    else $error("status read did not clear link loss");
  prbs_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ5
    (prbs_q && !i_stat.prbs_clr) |=> prbs_q)
    else $error("prbs error indication dropped early");
  rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ15
    (i_rd && i_addr == `PLS_ADR_CMP) |=> o_rdata[15:5] == 11'h000)
    else $error("reserved bits read nonzero");
  txm_follow_a: assert property (@(posedge i_clk) disable iff (!i_nrst) // RQ7
    $rose(txm_q[0]) |=> o_txm.en && (o_txm.tx_bit || o_txm.sr_clr))
    else $error("100M test did not start");
endmodule // pls_top
`default_nettype wire

// ==== verif/pls_line_mon.sv ====
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------
// line test equipment: gap meter
// ---------------------------------
module pls_line_mon (
  input wire logic i_clk, // core clock
  input wire logic i_nrst, // async reset, low
  input wire pls_pkg::pls_txm_s i_txm, // test stream from block
  output logic [5:0] o_gap // zeros seen between last two ones
);
  logic [5:0] zeros_q;
  // counts zeros only while the test mode is on
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      zeros_q <= 6'h00;
      o_gap <= 6'h00;
    end
    else if (!i_txm.en)
      zeros_q <= 6'h00;
    else if (i_txm.tx_bit)
    begin
      o_gap <= zeros_q;
      zeros_q <= 6'h00;
    end
    else
      zeros_q <= zeros_q + 6'h01;
  end
endmodule // pls_line_mon
`default_nettype wire

// ==== verif/test_phy_led_select_and_test_pattern.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "pls_cfg.svh"
module test_phy_led_select_and_test_pattern;
  logic clk;
  logic nrst;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [15:0] rdata;
  pls_pkg::pls_stat_s stat;
  logic led;
  pls_pkg::pls_tp10_s tp10;
  pls_pkg::pls_txm_s txm;
  logic [5:0] gap;
  logic [15:0] got;
  int err_total;
  int check_count;
  pls_top #(.BLINK_CYC(4), .STRETCH_CYC(4)) dut_u (.i_clk(clk), .i_nrst(nrst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_stat(stat), .o_led(led),
    .o_tp10(tp10), .o_txm(txm));
  pls_line_mon mon_u (.i_clk(clk), .i_nrst(nrst), .i_txm(txm), .o_gap(gap));
  // ---------------------------------
  // clock and watchdog
  // ---------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    chk("watchdog", 16'h0000, 16'h0001);
    give_verdict();
  end
  // ---------------------------------
  // tasks
  // ---------------------------------
  task automatic give_verdict();
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    got = rdata;
  endtask
  task automatic put(input logic [11:0] s);
    @(posedge clk);
    stat <= s;
  endtask
  task automatic led_is(input logic e, input int n);
    repeat (n) @(posedge clk);
    #1;
    chk("led", {15'h0000, e}, {15'h0000, led});
  endtask
  task automatic src(input logic [3:0] c, input logic route);
    wr(`PLS_ADR_IND, {9'h000, c, 2'h0, route});
  endtask
  // ---------------------------------
  // main sequence
  // ---------------------------------
  initial
  begin
    logic [11:0] on_mask [13];
    logic [4:0] nlist [5];
    on_mask = '{12'h800, 12'h400, 12'h200, 12'h100, 12'h080, 12'h040, 12'h020, 12'h010,
      12'h800, 12'h400, 12'h850, 12'h008, 12'h004};
    nlist = '{5'h01, 5'h02, 5'h07, 5'h1f, 5'h00};
    nrst = 1'b0;
    addr = 16'h0000;
    wdata = 16'h0000;
    wr_s = 1'b0;
    rd_s = 1'b0;
    stat = '0;
    err_total = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    chk("led_rst", 16'h0000, {15'h0000, led});
    nrst <= 1'b1;
    rd(`PLS_ADR_IND);
    chk("ind_rst", 16'h0041, got);
    rd(`PLS_ADR_CMP);
    chk("cmp_rst", 16'h0000, got);
    rd(16'h0030);
    chk("unmapped", 16'h0000, got);
    wr(`PLS_ADR_IND, 16'hffff);
    rd(`PLS_ADR_IND);
    chk("ind_rsv", 16'h0079, got);
    wr(`PLS_ADR_CMP, 16'hffff);
    rd(`PLS_ADR_CMP);
    chk("cmp_rsv", 16'h001f, got);
    wr(`PLS_ADR_TXM, 16'hffff);
    rd(`PLS_ADR_TXM);
    chk("txm_rsv", 16'h0030, got);
    wr(`PLS_ADR_TXM, 16'h0000);
    for (int c = 0; c < 13; c++)
    begin
      src(c[3:0], 1'b1);
      put(on_mask[c]);
      led_is(1'b1, 8);
      if (c != 8)
      begin
        put(12'hffc & ~on_mask[c]);
        led_is(1'b0, 8);
      end
    end
    src(4'h4, 1'b0);
    put(12'h800);
    led_is(1'b1, 8);
    put(12'h080);
    led_is(1'b0, 8);
    // link loss latch, cleared by status read
    src(4'hd, 1'b1);
    put(12'h800);
    rd(`PLS_ADR_BSR);
    led_is(1'b0, 4);
    put(12'h000);
    led_is(1'b1, 3);
    led_is(1'b1, 10);
    rd(`PLS_ADR_BSR);
    led_is(1'b0, 3);
    // single test-sequence error latch
    src(4'he, 1'b1);
    put(12'h001);
    put(12'h000);
    led_is(1'b0, 4);
    put(12'h002);
    put(12'h000);
    led_is(1'b1, 10);
    put(12'h001);
    put(12'h000);
    led_is(1'b0, 4);
    for (int c = 0; c < 14; c++)
    begin
      wr(`PLS_ADR_CMP, 16'h0010 | c[15:0]);
      repeat (2) @(posedge clk);
      #1;
      chk("tp10", {11'h000, 1'b1, c[3:0]}, {11'h000, tp10});
    end
    put(12'h040);
    foreach (nlist[i])
    begin
      wr(`PLS_ADR_CMP, {12'h000, nlist[i][3:0]});
      wr(`PLS_ADR_TXM, {10'h000, nlist[i][4], 5'h00});
      wr(`PLS_ADR_TXM, {10'h000, nlist[i][4], 5'h10});
      repeat (80) @(posedge clk);
      #1;
      chk("txm_en", 16'h0001, {15'h0000, txm.en});
      chk("sr_clr", {15'h0000, nlist[i] == 5'h00}, {15'h0000, txm.sr_clr});
      if (nlist[i] == 5'h00)
        chk("tx_bit", 16'h0000, {15'h0000, txm.tx_bit});
      else
        chk("gap", {11'h000, nlist[i]}, {10'h000, gap});
    end
    give_verdict();
  end
endmodule // test_phy_led_select_and_test_pattern
`default_nettype wire
